/* File: include/ufc_defs.svh */
// Constants of the serial channel flow, trigger and divisor configuration block.
// Contract
// - Low four control bits pick software flow mode.
// - Control bit 4 unlocks protected enable, FIFO, modem bits.
// - Special detect flags characters matching second Xoff.
// - Automatic RTS follows halt and restore thresholds.
// - Automatic CTS halts transmission while CTS high.
// - Baud divisor is sixteen bits in two bytes.
// - Divisor bytes writable only before sleep enabled.
// - Threshold register holds halt low, restore high nibble.
// - Threshold writes need control bit 4 and modem bit 6.
// - Trigger register holds transmit low, receive high nibble.
// - Trigger writes need control bit 4 and modem bit 6.
// - Zero trigger nibble falls back to FIFO control level.
// - Ready bits 0,1 show transmit space at trigger.
// - Ready bits 4,5 show receive above trigger or timeout.
// - Ready register read at address 7 when enabled.
// - Modem bit 6 opens threshold and trigger access.
// - Modem bit 4 loops transmit back to receive.
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH

`define UFC_A_DLL       3'h0
`define UFC_A_DLH       3'h1
`define UFC_A_IER       3'h1
`define UFC_A_FCR       3'h2
`define UFC_A_IIR       3'h2
`define UFC_A_EFR       3'h2
`define UFC_A_LCR       3'h3
`define UFC_A_MCR       3'h4
`define UFC_A_TCR       3'h6
`define UFC_A_TLR       3'h7
`define UFC_A_FRDY      3'h7
`define UFC_A_XOFF2     3'h7

`define UFC_LCR_EFR_KEY 8'hbf
`define UFC_LCR_DLAB    7
`define UFC_EFR_WEN     4
`define UFC_EFR_SCD     5
`define UFC_EFR_ARTS    6
`define UFC_EFR_ACTS    7
`define UFC_IER_SLEEP   4
`define UFC_FCR_EN      0
`define UFC_MCR_RTS     1
`define UFC_MCR_FRDY    2
`define UFC_MCR_LOOP    4
`define UFC_MCR_TLREN   6

`define UFC_IER_PROT    8'hf0
`define UFC_FCR_PROT    8'h30
`define UFC_MCR_PROT    8'he0
`define UFC_RST_BYTE    8'h00
`define UFC_ZERO_NIB    4'h0

`define UFC_TX_TRIG0    7'h08
`define UFC_TX_TRIG1    7'h10
`define UFC_TX_TRIG2    7'h20
`define UFC_TX_TRIG3    7'h38
`define UFC_RX_TRIG0    7'h08
`define UFC_RX_TRIG1    7'h10
`define UFC_RX_TRIG2    7'h38
`define UFC_RX_TRIG3    7'h3c

`define UFC_IIR_NONE    4'h1
`define UFC_IIR_SPECIAL 4'h0
`define UFC_DIV_ONE     16'h0001

`endif

/* File: include/ufc_pkg.sv */
// Types shared by the configuration block files.
package ufc_pkg;
  typedef enum logic {UFC_TX_RUN, UFC_TX_HALT} ufc_tx_state_t;
  typedef logic [7:0] ufc_byte_t;
  typedef logic [6:0] ufc_level_t;
endpackage

/* File: rtl/ufc_sync.sv */
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
module ufc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = clk_en ? async_in : meta_r;
    sync_nxt = clk_en ? meta_r : sync_out;
  end

  // Reset loads all ones, the idle level of the select and strobe pins routed through here.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r   <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_r   <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule

/* File: rtl/ufc_baud.sv */
// Baud rate divider producing one tick per divisor period.
`timescale 1ns/1ps
`include "ufc_defs.svh"
module ufc_baud (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [15:0] divisor,
  output logic             baud_tick
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_nxt;

  // A zero divisor stops the generator.
  always_comb
  begin
    cnt_nxt  = cnt_r;
    tick_nxt = baud_tick;
    if (clk_en)
    begin
      tick_nxt = 1'b0;
      if (divisor == 16'h0000)
        cnt_nxt = 16'h0000;
      else if (cnt_r >= divisor - `UFC_DIV_ONE)
      begin
        cnt_nxt  = 16'h0000;
        tick_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + `UFC_DIV_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r     <= 16'h0000;
      baud_tick <= 1'b0;
    end
    else
    begin
      cnt_r     <= cnt_nxt;
      baud_tick <= tick_nxt;
    end
  end
endmodule

/* File: rtl/ufc_top.sv */
// Flow control, trigger level, divisor and FIFO ready configuration of serial channel A.
`timescale 1ns/1ps
`include "ufc_defs.svh"
module ufc_top (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  input  wire logic       channel_a_select_n,
  input  wire logic       channel_b_select_n,
  input  wire logic       bus_rd_n,
  input  wire logic       bus_wr_n,
  input  wire logic [2:0] bus_addr,
  input  wire logic [7:0] bus_din,
  output logic      [7:0] bus_dout,
  output logic            bus_doe,
  input  wire logic       chb_fifo_rdy_en,
  input  wire logic       chb_tx_ready,
  input  wire logic       chb_rx_ready,
  input  wire logic [6:0] rx_fifo_level,
  input  wire logic [6:0] tx_fifo_free,
  input  wire logic       rx_timeout,
  input  wire logic       rx_char_valid,
  input  wire logic [7:0] rx_char,
  input  wire logic       tx_busy,
  input  wire logic       tx_serial,
  input  wire logic       rx_pin,
  input  wire logic       cts_n,
  output logic            rts_n,
  output logic            tx_pin,
  output logic            rx_serial,
  output logic            tx_allow,
  output logic            baud_tick,
  output logic            special_char,
  output logic      [3:0] swfc_mode,
  output logic      [6:0] tx_trig_level,
  output logic      [6:0] rx_trig_level,
  output logic            sleep_mode
);
  localparam int SW = 17;
  logic                   rst_meta_r, rst_n;
  logic [SW-1:0]          pins_s;
  logic                   sel_a, sel_b, rd_s, wr_s, cts_hi_s, rx_pin_s;
  logic [2:0]             addr_s;
  logic [7:0]             din_s;
  logic                   wr_q_r, rd_q_r, wr_evt, rd_end;
  ufc_pkg::ufc_byte_t     lcr_r, ier_r, fcr_r, mcr_r, efr_r, dll_r, dlh_r, tcr_r, tlr_r, xoff2_r;
  ufc_pkg::ufc_byte_t     lcr_nxt, ier_nxt, fcr_nxt, mcr_nxt, efr_nxt, dll_nxt, dlh_nxt, tcr_nxt, tlr_nxt;
  ufc_pkg::ufc_byte_t     xoff2_nxt, dout_nxt, frdy_val, iir_val;
  logic                   sc_flag_r, sc_flag_nxt, doe_nxt, special_nxt, sc_hit;
  logic                   bank_key, bank_dlab, tcr_open, frdy_ok;
  ufc_pkg::ufc_tx_state_t tx_state_r, tx_state_nxt;
  logic                   rts_n_nxt, tx_pin_nxt, rx_serial_nxt, tx_allow_nxt, cts_hi_eff, sleep_nxt;
  ufc_pkg::ufc_level_t    halt_lvl, restore_lvl, tx_trig_nxt, rx_trig_nxt;
  logic [3:0]             swfc_nxt;
  // Keeps the old bits inside the protected mask unless the write enable is set.
  function automatic ufc_pkg::ufc_byte_t merge_prot(input ufc_pkg::ufc_byte_t old_v,
                                                    input ufc_pkg::ufc_byte_t new_v,
                                                    input ufc_pkg::ufc_byte_t mask,
                                                    input logic               wen);
    merge_prot = wen ? new_v : ((old_v & mask) | (new_v & ~mask));
  endfunction

  // Turns a nibble in steps of four into a byte count.
  function automatic ufc_pkg::ufc_level_t nib_level(input logic [3:0] nib);
    nib_level = {1'b0, nib, 2'b00};
  endfunction

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  ufc_sync #(.WIDTH (SW)) u_pin_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .async_in  ({channel_a_select_n, channel_b_select_n, bus_rd_n, bus_wr_n, bus_addr, bus_din, cts_n, rx_pin}),
    .sync_out  (pins_s)
  );

  assign sel_a    = ~pins_s[16];
  assign sel_b    = ~pins_s[15];
  assign rd_s     = ~pins_s[14];
  assign wr_s     = ~pins_s[13];
  assign addr_s   = pins_s[12:10];
  assign din_s    = pins_s[9:2];
  assign cts_hi_s = pins_s[1];
  assign rx_pin_s = pins_s[0];

  ufc_baud u_baud (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .divisor   ({dlh_r, dll_r}),
    .baud_tick (baud_tick)
  );

  // A write is taken when the strobe ends, with data still held by the host.
  assign wr_evt    = clk_en & wr_q_r & ~wr_s & sel_a;
  assign rd_end    = clk_en & rd_q_r & ~rd_s & sel_a;
  assign bank_key  = (lcr_r == `UFC_LCR_EFR_KEY);
  assign bank_dlab = lcr_r[`UFC_LCR_DLAB] & ~bank_key;
  assign tcr_open  = efr_r[`UFC_EFR_WEN] & mcr_r[`UFC_MCR_TLREN];
  assign frdy_ok   = (sel_a & mcr_r[`UFC_MCR_FRDY] & ~mcr_r[`UFC_MCR_LOOP]) | (sel_b & chb_fifo_rdy_en);
  assign sc_hit    = clk_en & rx_char_valid & efr_r[`UFC_EFR_SCD] & (rx_char == xoff2_r);
  assign frdy_val  = {2'b00, chb_rx_ready, (rx_fifo_level > rx_trig_level) | rx_timeout,
                      2'b00, chb_tx_ready, (tx_fifo_free >= tx_trig_level)};
  assign iir_val   = {fcr_r[`UFC_FCR_EN], fcr_r[`UFC_FCR_EN], 1'b0, sc_flag_r,
                      sc_flag_r ? `UFC_IIR_SPECIAL : `UFC_IIR_NONE};

  always_comb
  begin
    lcr_nxt     = lcr_r;
    ier_nxt     = ier_r;
    fcr_nxt     = fcr_r;
    mcr_nxt     = mcr_r;
    efr_nxt     = efr_r;
    dll_nxt     = dll_r;
    dlh_nxt     = dlh_r;
    tcr_nxt     = tcr_r;
    tlr_nxt     = tlr_r;
    xoff2_nxt   = xoff2_r;
    sc_flag_nxt = sc_flag_r;
    dout_nxt    = bus_dout;
    doe_nxt     = bus_doe;
    special_nxt = clk_en ? sc_hit : special_char;
    if (wr_evt)
    begin
      if (addr_s == `UFC_A_LCR)
        lcr_nxt = din_s;
      else if (bank_key)
      begin
        if (addr_s == `UFC_A_EFR)
          efr_nxt = din_s;
        else if (addr_s == `UFC_A_XOFF2)
          xoff2_nxt = din_s;
      end
      else if (bank_dlab)
      begin
        if (addr_s == `UFC_A_DLL && !ier_r[`UFC_IER_SLEEP])
          dll_nxt = din_s;
        else if (addr_s == `UFC_A_DLH && !ier_r[`UFC_IER_SLEEP])
          dlh_nxt = din_s;
      end
      else if (addr_s == `UFC_A_IER)
        ier_nxt = merge_prot(ier_r, din_s, `UFC_IER_PROT, efr_r[`UFC_EFR_WEN]);
      else if (addr_s == `UFC_A_FCR)
        fcr_nxt = merge_prot(fcr_r, din_s, `UFC_FCR_PROT, efr_r[`UFC_EFR_WEN]);
      else if (addr_s == `UFC_A_MCR)
        mcr_nxt = merge_prot(mcr_r, din_s, `UFC_MCR_PROT, efr_r[`UFC_EFR_WEN]);
      else if (addr_s == `UFC_A_TCR && tcr_open)
        tcr_nxt = din_s;
      else if (addr_s == `UFC_A_TLR && tcr_open)
        tlr_nxt = din_s;
    end
    // Reading the identification register clears the special flag; a new match wins.
    if (rd_end && !bank_key && !bank_dlab && addr_s == `UFC_A_IIR)
      sc_flag_nxt = 1'b0;
    if (sc_hit)
      sc_flag_nxt = 1'b1;
    if (clk_en)
    begin
      doe_nxt  = rd_s & (sel_a | (sel_b & frdy_ok & addr_s == `UFC_A_FRDY));
      dout_nxt = `UFC_RST_BYTE;
      if (addr_s == `UFC_A_LCR)
        dout_nxt = lcr_r;
      else if (bank_key)
      begin
        if (addr_s == `UFC_A_EFR)
          dout_nxt = efr_r;
        else if (addr_s == `UFC_A_XOFF2)
          dout_nxt = xoff2_r;
      end
      else if (bank_dlab)
      begin
        if (addr_s == `UFC_A_DLL)
          dout_nxt = dll_r;
        else if (addr_s == `UFC_A_DLH)
          dout_nxt = dlh_r;
      end
      else if (addr_s == `UFC_A_FRDY && frdy_ok)
        dout_nxt = frdy_val;
      else if (addr_s == `UFC_A_IER)
        dout_nxt = ier_r;
      else if (addr_s == `UFC_A_IIR)
        dout_nxt = iir_val;
      else if (addr_s == `UFC_A_MCR)
        dout_nxt = mcr_r;
      else if (addr_s == `UFC_A_TCR && tcr_open)
        dout_nxt = tcr_r;
      else if (addr_s == `UFC_A_TLR && tcr_open)
        dout_nxt = tlr_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q_r       <= 1'b0;
      rd_q_r       <= 1'b0;
      lcr_r        <= `UFC_RST_BYTE;
      ier_r        <= `UFC_RST_BYTE;
      fcr_r        <= `UFC_RST_BYTE;
      mcr_r        <= `UFC_RST_BYTE;
      efr_r        <= `UFC_RST_BYTE;
      dll_r        <= `UFC_RST_BYTE;
      dlh_r        <= `UFC_RST_BYTE;
      tcr_r        <= `UFC_RST_BYTE;
      tlr_r        <= `UFC_RST_BYTE;
      xoff2_r      <= `UFC_RST_BYTE;
      sc_flag_r    <= 1'b0;
      bus_dout     <= `UFC_RST_BYTE;
      bus_doe      <= 1'b0;
      special_char <= 1'b0;
    end
    else
    begin
      wr_q_r       <= clk_en ? wr_s : wr_q_r;
      rd_q_r       <= clk_en ? rd_s : rd_q_r;
      lcr_r        <= lcr_nxt;
      ier_r        <= ier_nxt;
      fcr_r        <= fcr_nxt;
      mcr_r        <= mcr_nxt;
      efr_r        <= efr_nxt;
      dll_r        <= dll_nxt;
      dlh_r        <= dlh_nxt;
      tcr_r        <= tcr_nxt;
      tlr_r        <= tlr_nxt;
      xoff2_r      <= xoff2_nxt;
      sc_flag_r    <= sc_flag_nxt;
      bus_dout     <= dout_nxt;
      bus_doe      <= doe_nxt;
      special_char <= special_nxt;
    end
  end

  assign halt_lvl    = nib_level(tcr_r[3:0]);
  assign restore_lvl = nib_level(tcr_r[7:4]);
  // In loopback the modem RTS bit stands in for the CTS pin.
  assign cts_hi_eff  = mcr_r[`UFC_MCR_LOOP] ? ~mcr_r[`UFC_MCR_RTS] : cts_hi_s;

  always_comb
  begin
    tx_state_nxt  = tx_state_r;
    rts_n_nxt     = rts_n;
    tx_pin_nxt    = tx_pin;
    rx_serial_nxt = rx_serial;
    tx_allow_nxt  = tx_allow;
    tx_trig_nxt   = tx_trig_level;
    rx_trig_nxt   = rx_trig_level;
    swfc_nxt      = swfc_mode;
    sleep_nxt     = sleep_mode;
    if (clk_en)
    begin
      swfc_nxt  = efr_r[3:0];
      sleep_nxt = ier_r[`UFC_IER_SLEEP];
      if (mcr_r[`UFC_MCR_LOOP])
      begin
        rts_n_nxt     = 1'b1;
        tx_pin_nxt    = 1'b1;
        rx_serial_nxt = tx_serial;
      end
      else
      begin
        tx_pin_nxt    = tx_serial;
        rx_serial_nxt = rx_pin_s;
        if (!efr_r[`UFC_EFR_ARTS])
          rts_n_nxt = ~mcr_r[`UFC_MCR_RTS];
        else if (rx_fifo_level >= halt_lvl)
          rts_n_nxt = 1'b1;
        else if (rx_fifo_level <= restore_lvl)
          rts_n_nxt = 1'b0;
      end
      // The halt state only changes between characters.
      case (tx_state_r)
        ufc_pkg::UFC_TX_RUN:
          if (efr_r[`UFC_EFR_ACTS] && cts_hi_eff && !tx_busy)
            tx_state_nxt = ufc_pkg::UFC_TX_HALT;
        ufc_pkg::UFC_TX_HALT:
          if ((!efr_r[`UFC_EFR_ACTS] || !cts_hi_eff) && !tx_busy)
            tx_state_nxt = ufc_pkg::UFC_TX_RUN;
        default:
          tx_state_nxt = ufc_pkg::UFC_TX_RUN;
      endcase
      tx_allow_nxt = (tx_state_nxt == ufc_pkg::UFC_TX_RUN);
      case (fcr_r[5:4])
        2'b00:   tx_trig_nxt = `UFC_TX_TRIG0;
        2'b01:   tx_trig_nxt = `UFC_TX_TRIG1;
        2'b10:   tx_trig_nxt = `UFC_TX_TRIG2;
        default: tx_trig_nxt = `UFC_TX_TRIG3;
      endcase
      case (fcr_r[7:6])
        2'b00:   rx_trig_nxt = `UFC_RX_TRIG0;
        2'b01:   rx_trig_nxt = `UFC_RX_TRIG1;
        2'b10:   rx_trig_nxt = `UFC_RX_TRIG2;
        default: rx_trig_nxt = `UFC_RX_TRIG3;
      endcase
      if (tlr_r[3:0] != `UFC_ZERO_NIB)
        tx_trig_nxt = nib_level(tlr_r[3:0]);
      if (tlr_r[7:4] != `UFC_ZERO_NIB)
        rx_trig_nxt = nib_level(tlr_r[7:4]);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_r    <= ufc_pkg::UFC_TX_RUN;
      rts_n         <= 1'b1;
      tx_pin        <= 1'b1;
      rx_serial     <= 1'b1;
      tx_allow      <= 1'b1;
      tx_trig_level <= `UFC_TX_TRIG0;
      rx_trig_level <= `UFC_RX_TRIG0;
      swfc_mode     <= `UFC_ZERO_NIB;
      sleep_mode    <= 1'b0;
    end
    else
    begin
      tx_state_r    <= tx_state_nxt;
      rts_n         <= rts_n_nxt;
      tx_pin        <= tx_pin_nxt;
      rx_serial     <= rx_serial_nxt;
      tx_allow      <= tx_allow_nxt;
      tx_trig_level <= tx_trig_nxt;
      rx_trig_level <= rx_trig_nxt;
      swfc_mode     <= swfc_nxt;
      sleep_mode    <= sleep_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_swfc_follow;
    clk_en |=> swfc_mode == $past(efr_r[3:0]);
  endproperty
  a_swfc_follow: assert property (p_swfc_follow) else $error("soft flow mode not taken from control");
  property p_ier_locked;
    wr_evt && !efr_r[`UFC_EFR_WEN] && !bank_key && !bank_dlab && addr_s == `UFC_A_IER
      |=> ier_r[7:4] == $past(ier_r[7:4]);
  endproperty
  a_ier_locked: assert property (p_ier_locked) else $error("protected enable bits changed");
  property p_special_hit;
    sc_hit |=> sc_flag_r && special_char;
  endproperty
  a_special_hit: assert property (p_special_hit) else $error("special character not flagged");
  property p_rts_halt;
    clk_en && efr_r[`UFC_EFR_ARTS] && !mcr_r[`UFC_MCR_LOOP] && rx_fifo_level >= halt_lvl |=> rts_n;
  endproperty
  a_rts_halt: assert property (p_rts_halt) else $error("RTS not raised at halt level");
  property p_cts_allow;
    clk_en && efr_r[`UFC_EFR_ACTS] && cts_hi_eff && !tx_busy |=> !tx_allow;
  endproperty
  a_cts_allow: assert property (p_cts_allow) else $error("transmit not halted while CTS high");
  property p_char_boundary;
    clk_en && tx_busy |=> $stable(tx_allow);
  endproperty
  a_char_boundary: assert property (p_char_boundary) else $error("permission changed inside a character");
  property p_div_sleep;
    ier_r[`UFC_IER_SLEEP] |=> {dlh_r, dll_r} == $past({dlh_r, dll_r});
  endproperty
  a_div_sleep: assert property (p_div_sleep) else $error("divisor changed in sleep");
  property p_tcr_locked;
    wr_evt && !tcr_open |=> tcr_r == $past(tcr_r) && tlr_r == $past(tlr_r);
  endproperty
  a_tcr_locked: assert property (p_tcr_locked) else $error("threshold or trigger written while closed");
  property p_tlr_override;
    clk_en && tlr_r[3:0] != `UFC_ZERO_NIB |=> tx_trig_level == {1'b0, $past(tlr_r[3:0]), 2'b00};
  endproperty
  a_tlr_override: assert property (p_tlr_override) else $error("transmit trigger not from nibble");

  c_cts_halt: cover property (tx_state_r == ufc_pkg::UFC_TX_RUN ##1 tx_state_r == ufc_pkg::UFC_TX_HALT);
  c_frdy_read: cover property (bus_doe && bus_dout[4]);
  c_special: cover property (sc_hit);
  c_rts_high: cover property (efr_r[`UFC_EFR_ARTS] && rts_n);
endmodule

/* File: test/ufc_peer.sv */
// Remote serial peer that throttles the channel through its CTS line.
`timescale 1ns/1ps
module ufc_peer (
  input  wire logic stop_req,
  input  wire logic rts_n,
  input  wire logic tx_pin,
  output logic      cts_n,
  output logic      rx_pin
);
  // The peer asks the channel to stop by raising CTS, active low at the pin.
  assign cts_n  = stop_req;
  // The peer echoes the channel's own output, so the line idles at mark after reset.
  assign rx_pin = tx_pin;
endmodule

/* File: test/uart_flow_trigger_config_tb_top.sv */
// Register and flow control tests of the serial channel configuration block.
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    check_count++; \
    if ((a) !== (e)) \
    begin \
      n_errors++; \
      $display("Error at %0t: got %h expected %h", $time, a, e); \
    end \
  end
module uart_flow_trigger_config_tb_top;
  logic       sys_clk = 0;
  logic       resetn = 0;
  logic       csa_n = 1, csb_n = 1, rd_n = 1, wr_n = 1;
  logic [2:0] addr = 0;
  logic [7:0] din = 0, dout, d;
  logic       doe, chb_en = 0, chb_tx = 0, chb_rx = 0, tmo = 0;
  logic [6:0] rx_lvl = 0, tx_free = 0, tx_trig, rx_trig;
  logic       cv = 0, busy = 0, tx_ser = 1, rx_pin, cts_n, rts_n, stop = 0;
  logic       tx_pin, rx_ser, tx_allow, tick, spec, sleep, ds;
  logic [7:0] ch = 0;
  logic [3:0] swfc;
  int         n_errors = 0, check_count = 0, cyc = 0, n;

  always #4 sys_clk = ~sys_clk;

  ufc_peer peer (.stop_req(stop), .rts_n(rts_n), .tx_pin(tx_pin), .cts_n(cts_n), .rx_pin(rx_pin));

  ufc_top uut (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1), .channel_a_select_n(csa_n),
    .channel_b_select_n(csb_n), .bus_rd_n(rd_n), .bus_wr_n(wr_n), .bus_addr(addr),
    .bus_din(din), .bus_dout(dout), .bus_doe(doe), .chb_fifo_rdy_en(chb_en),
    .chb_tx_ready(chb_tx), .chb_rx_ready(chb_rx), .rx_fifo_level(rx_lvl),
    .tx_fifo_free(tx_free), .rx_timeout(tmo), .rx_char_valid(cv), .rx_char(ch),
    .tx_busy(busy), .tx_serial(tx_ser), .rx_pin(rx_pin), .cts_n(cts_n), .rts_n(rts_n),
    .tx_pin(tx_pin), .rx_serial(rx_ser), .tx_allow(tx_allow), .baud_tick(tick),
    .special_char(spec), .swfc_mode(swfc), .tx_trig_level(tx_trig),
    .rx_trig_level(rx_trig), .sleep_mode(sleep));

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 4000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  // Write strobe held three cycles; data stays on the pins until the capture lands.
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    csa_n <= 0;
    wr_n  <= 0;
    addr  <= a;
    din   <= v;
    repeat (3) @(posedge sys_clk);
    wr_n <= 1;
    repeat (4) @(posedge sys_clk);
    csa_n <= 1;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic rd(input logic cb, input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    csa_n <= cb;
    csb_n <= ~cb;
    rd_n  <= 0;
    addr  <= a;
    repeat (5) @(posedge sys_clk);
    v  = dout;
    ds = doe;
    rd_n <= 1;
    // Select stays low until the strobe end has been seen, so a read side effect lands.
    repeat (4) @(posedge sys_clk);
    csa_n <= 1;
    csb_n <= 1;
    repeat (3) @(posedge sys_clk);
  endtask

  // Reading at a rising edge sees the values settled after the k-th edge.
  task automatic waitn(input int k);
    repeat (k + 1) @(posedge sys_clk);
  endtask

  task automatic pulse_char(input logic [7:0] c);
    @(posedge sys_clk);
    cv <= 1;
    ch <= c;
    @(posedge sys_clk);
    cv <= 0;
    n = 0;
    repeat (4)
    begin
      @(negedge sys_clk);
      n += spec;
    end
  endtask

  initial
  begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1;
    waitn(6);
    `CHK({swfc, tx_trig, rx_trig, sleep, rts_n}, {4'h0, 7'h08, 7'h08, 1'b0, 1'b1})
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'h15);
    `CHK(swfc, 4'h5)
    rd(0, 3'h2, d);
    `CHK(d, 8'h15)
    $display("enhanced control done");
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h03);
    wr(3'h1, 8'h00);
    rd(0, 3'h0, d);
    `CHK(d, 8'h03)
    n = 0;
    repeat (30)
    begin
      @(negedge sys_clk);
      n += tick;
    end
    `CHK(n[7:0], 8'h0a)
    $display("divisor done");
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h44);
    rd(0, 3'h4, d);
    `CHK(d, 8'h44)
    wr(3'h7, 8'h53);
    waitn(1);
    `CHK({tx_trig, rx_trig}, {7'h0c, 7'h14})
    // Halt level stays above restore level, as software must arrange.
    wr(3'h6, 8'h28);
    rd(0, 3'h6, d);
    `CHK(d, 8'h28)
    tx_free <= 7'h0c;
    rx_lvl  <= 7'h14;
    chb_rx  <= 1;
    rd(0, 3'h7, d);
    `CHK(d, 8'h21)
    tx_free <= 7'h0b;
    rx_lvl  <= 7'h15;
    chb_tx  <= 1;
    chb_rx  <= 0;
    rd(0, 3'h7, d);
    `CHK(d, 8'h12)
    tx_free <= 7'h0c;
    rx_lvl  <= 7'h00;
    tmo     <= 1;
    chb_en  <= 1;
    rd(1, 3'h7, d);
    `CHK({ds, d}, 9'h113)
    tmo    <= 0;
    chb_en <= 0;
    rd(1, 3'h7, d);
    `CHK(ds, 1'b0)
    wr(3'h7, 8'h00);
    waitn(1);
    `CHK({tx_trig, rx_trig}, {7'h08, 7'h08})
    $display("levels and ready done");
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    rd(0, 3'h4, d);
    `CHK(d, 8'h40)
    wr(3'h1, 8'hff);
    rd(0, 3'h1, d);
    `CHK(d, 8'h0f)
    wr(3'h6, 8'h11);
    rd(0, 3'h6, d);
    `CHK(d, 8'h00)
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'hf0);
    wr(3'h7, 8'h13);
    wr(3'h3, 8'h00);
    rd(0, 3'h6, d);
    `CHK(d, 8'h28)
    $display("write protection done");
    rx_lvl <= 7'h20;
    waitn(2);
    `CHK(rts_n, 1'b1)
    rx_lvl <= 7'h14;
    waitn(2);
    `CHK(rts_n, 1'b1)
    rx_lvl <= 7'h08;
    waitn(2);
    `CHK(rts_n, 1'b0)
    busy <= 1;
    stop <= 1;
    waitn(5);
    `CHK(tx_allow, 1'b1)
    busy <= 0;
    waitn(2);
    `CHK(tx_allow, 1'b0)
    stop <= 0;
    waitn(4);
    `CHK(tx_allow, 1'b1)
    $display("auto flow done");
    pulse_char(8'h14);
    `CHK(n[7:0], 8'h00)
    pulse_char(8'h13);
    `CHK(n[7:0], 8'h01)
    rd(0, 3'h2, d);
    `CHK(d, 8'h10)
    rd(0, 3'h2, d);
    `CHK(d, 8'h01)
    $display("special character done");
    // A divisor write once sleep is entered is ignored; the earlier value 03 stays.
    wr(3'h1, 8'h10);
    waitn(1);
    `CHK(sleep, 1'b1)
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h05);
    rd(0, 3'h0, d);
    `CHK(d, 8'h03)
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h50);
    tx_ser <= 0;
    waitn(4);
    `CHK({rx_ser, tx_pin}, 2'b01)
    rd(0, 3'h7, d);
    `CHK(d, 8'h00)
    $display("sleep and loopback done");
    report_and_stop();
  end
endmodule
